// >>> design/dmc_cfg.svh
// Offsets, field positions, reset values and fixed counts of the DMA
// channel control block.
// Assumes byte addresses on a 9-bit register port, one word per register.
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH

`define DMC_CH_COUNT 4
`define DMC_ADDR_W 9
`define DMC_CORE_PAGE_BIT 8
`define DMC_OFF_RD_STATIC 6'h00
`define DMC_OFF_WR_STATIC 6'h04
`define DMC_OFF_MODE_STATIC 6'h08
`define DMC_OFF_PERIPH_SEL 6'h10
`define DMC_OFF_CMD_SRC 6'h14
`define DMC_OFF_CMD_DST 6'h18
`define DMC_OFF_CMD_LEN 6'h1C
`define DMC_OFF_CMD_LINK 6'h20
`define DMC_OFF_IRQ_EN 6'h24
`define DMC_OFF_RUN 6'h28
`define DMC_OFF_KICK 6'h2C
`define DMC_OFF_IRQ_FLAGS 6'h30
`define DMC_OFF_ACTIVITY 6'h34
`define DMC_OFF_CORE_PAIRED 6'h00
`define DMC_OFF_CORE_IDLE 6'h04

`define DMC_BURST_LSB 0
`define DMC_BURST_W 7
`define DMC_TOK_LSB 16
`define DMC_TOK_W 6
`define DMC_INC_BIT 31
`define DMC_PAIR_BIT 28
`define DMC_RSEL_LSB 0
`define DMC_RWAIT_LSB 8
`define DMC_WSEL_LSB 16
`define DMC_WWAIT_LSB 24
`define DMC_SEL_W 5
`define DMC_WAIT_W 3
`define DMC_LEN_W 13
`define DMC_CMD_INT_BIT 0
`define DMC_CMD_LAST_BIT 1
`define DMC_FETCH_WORDS 4

`define DMC_CFG_RST 32'h00000000
`define DMC_LEN_RST 13'h0000

`endif

// >>> design/dmc_pkg.sv
// Types shared by the DMA channel control block.
// Assumes nothing of its surroundings.
package dmc_pkg;

	typedef enum logic [3:0] {
		PH_IDLE = 4'h1,
		PH_MOVE = 4'h2,
		PH_FETCH = 4'h4,
		PH_END = 4'h8
	} dmc_phase_t;

	typedef enum logic [1:0] {
		AR_IDLE = 2'h1,
		AR_BUSY = 2'h2
	} dmc_arb_t;

endpackage : dmc_pkg

// >>> design/dmc_channel_control.sv
// Four-channel DMA control: registers, per-channel sequencing and one
// shared bus-operation port toward the data mover.
// Assumes the mover answers each operation with a one-cycle opDone on
// core_clk; request lines arrive asynchronously from peripherals.
//
// Notes on behaviour
// RULE_01: Read burst size and read address step.
// RULE_02: Write burst size and write address step.
// RULE_03: Read tokens bound consecutive read commands.
// RULE_04: Write tokens bound consecutive write commands.
// RULE_05: Mode bit selects paired operation.
// RULE_06: Source request select; zero means memory.
// RULE_07: Source request wait cycles for peripherals.
// RULE_08: Destination request select; zero means memory.
// RULE_09: Destination request wait cycles for peripherals.
// RULE_10: Static fields at bits 0, 16, 31.
// RULE_11: Select fields at bits 0, 8, 16, 24.
// RULE_12: Software writes 0x03 for single transfer.
// RULE_13: Command holds source and destination addresses.
// RULE_14: Third command word holds 13-bit length.
// RULE_15: Interrupt enable gates done status.
// RULE_16: One interrupt output for all channels.
// RULE_17: Start needs enable; completion sets done.
// RULE_18: Channel stops after last command; busy clears.
// RULE_19: Clearing enable pauses after pending operation.
// RULE_20: Last flag stops after current buffer.
// RULE_21: Restart is disable, start, enable.
// RULE_22: Core idle once all channels stopped.
// RULE_23: Link word: interrupt, last, next address.
// RULE_24: Not last: fetch next command, else stop.
// RULE_25: Interrupt while any enabled done flag set.
// RULE_26: Start held until channel enabled.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_cfg.svh"

module dmc_channel_control
	import dmc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [`DMC_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata_ff,
	input wire logic [31:0] periphReq,
	output logic opValid_ff,
	output logic opFetch_ff,
	output logic [1:0] opChan_ff,
	output logic [31:0] opSrc_ff,
	output logic [31:0] opDst_ff,
	output logic [6:0] opBytes_ff,
	output logic opSrcStep_ff,
	output logic opDstStep_ff,
	output logic opPaired_ff,
	input wire logic opDone,
	input wire logic [31:0] opRdata,
	output logic irqOut_ff,
	output logic coreIdle_ff
);

	localparam int NCH = `DMC_CH_COUNT;

	initial
	begin
		if (NCH != 4)
			$error("dmc_channel_control serves exactly four channels");
	end

	logic [31:0] rdCfg_ff [NCH];
	logic [31:0] wrCfg_ff [NCH];
	logic [31:0] modeCfg_ff [NCH];
	logic [31:0] selCfg_ff [NCH];
	logic [31:0] cmdSrc_ff [NCH];
	logic [31:0] cmdDst_ff [NCH];
	logic [`DMC_LEN_W-1:0] cmdLen_ff [NCH];
	logic [31:0] cmdLink_ff [NCH];
	logic [31:0] fetchBase_ff [NCH];
	logic [1:0] fetchIdx_ff [NCH];
	logic [`DMC_WAIT_W-1:0] waitCnt_ff [NCH];
	dmc_phase_t phase_ff [NCH];
	logic [NCH-1:0] irqEn_ff;
	logic [NCH-1:0] run_ff;
	logic [NCH-1:0] kickPend_ff;
	logic [NCH-1:0] doneFlag_ff;
	logic corePaired_ff;
	logic [31:0] reqMeta_ff;
	logic [31:0] reqSync_ff;
	dmc_arb_t arb_ff;
	logic [1:0] owner_ff;
	logic [`DMC_TOK_W-1:0] tokLeft_ff;

	logic [5:0] off;
	logic [1:0] regCh;
	logic corePage;
	logic [NCH-1:0] chWr;
	logic [6:0] burst [NCH];
	logic [6:0] moveBytes [NCH];
	logic [`DMC_TOK_W-1:0] tok [NCH];
	logic [`DMC_WAIT_W-1:0] waitNeed [NCH];
	logic [NCH-1:0] paired;
	logic [NCH-1:0] reqHi;
	logic [NCH-1:0] ready;
	logic [NCH-1:0] opBack;
	logic [31:0] nxt_rdata;
	logic [1:0] start;
	logic [1:0] pick;
	logic [1:0] cand;
	logic found;
	logic issue;
	logic allIdle;

	assign off = regAddr[5:0];
	assign regCh = regAddr[7:6];
	assign corePage = regAddr[`DMC_CORE_PAGE_BIT];

	// Request lines pass two flops before anything looks at them.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			reqMeta_ff <= 32'h00000000;
			reqSync_ff <= 32'h00000000;
		end
		else
		begin
			reqMeta_ff <= periphReq;
			reqSync_ff <= reqMeta_ff;
		end
	end

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			chWr[i] = regWrite && !corePage && regCh == 2'(i);
			paired[i] = modeCfg_ff[i][`DMC_PAIR_BIT] && corePaired_ff; // RULE_05
			// Paired channels take burst and tokens from the read side only.
			burst[i] = rdCfg_ff[i][`DMC_BURST_LSB +: `DMC_BURST_W]; // RULE_01
			tok[i] = rdCfg_ff[i][`DMC_TOK_LSB +: `DMC_TOK_W]; // RULE_03
			if (!paired[i])
			begin
				if (wrCfg_ff[i][`DMC_BURST_LSB +: `DMC_BURST_W] < burst[i])
					burst[i] = wrCfg_ff[i][`DMC_BURST_LSB +: `DMC_BURST_W]; // RULE_02
				if (wrCfg_ff[i][`DMC_TOK_LSB +: `DMC_TOK_W] < tok[i])
					tok[i] = wrCfg_ff[i][`DMC_TOK_LSB +: `DMC_TOK_W]; // RULE_04
			end
			if (burst[i] == 7'h00)
				burst[i] = 7'h01;
			if (tok[i] == 6'h00)
				tok[i] = 6'h01;
			if (cmdLen_ff[i] < {6'h00, burst[i]})
				moveBytes[i] = cmdLen_ff[i][6:0];
			else
				moveBytes[i] = burst[i];
			reqHi[i] = 1'b1;
			waitNeed[i] = 3'h0;
			if (selCfg_ff[i][`DMC_RSEL_LSB +: `DMC_SEL_W] != 5'h00)
			begin
				reqHi[i] = reqSync_ff[selCfg_ff[i][`DMC_RSEL_LSB +: `DMC_SEL_W]]; // RULE_06
				waitNeed[i] = selCfg_ff[i][`DMC_RWAIT_LSB +: `DMC_WAIT_W]; // RULE_07
			end
			if (selCfg_ff[i][`DMC_WSEL_LSB +: `DMC_SEL_W] != 5'h00)
			begin
				reqHi[i] = reqHi[i]
					&& reqSync_ff[selCfg_ff[i][`DMC_WSEL_LSB +: `DMC_SEL_W]]; // RULE_08
				if (selCfg_ff[i][`DMC_WWAIT_LSB +: `DMC_WAIT_W] > waitNeed[i])
					waitNeed[i] = selCfg_ff[i][`DMC_WWAIT_LSB +: `DMC_WAIT_W]; // RULE_09
			end
			opBack[i] = arb_ff == AR_BUSY && opDone && owner_ff == 2'(i);
			ready[i] = run_ff[i] && !(arb_ff == AR_BUSY && owner_ff == 2'(i))
				&& (phase_ff[i] == PH_FETCH || (phase_ff[i] == PH_MOVE
				&& cmdLen_ff[i] != `DMC_LEN_RST && reqHi[i]
				&& waitCnt_ff[i] >= waitNeed[i])); // RULE_19
		end
	end

	// The owner keeps the search head while it still holds tokens.
	always_comb
	begin
		start = (tokLeft_ff != 6'h00) ? owner_ff : owner_ff + 2'h1; // RULE_03 RULE_04
		found = 1'b0;
		pick = 2'h0;
		cand = 2'h0;
		for (int k = 0; k < NCH; k++)
		begin
			cand = start + 2'(k);
			if (!found && ready[cand])
			begin
				found = 1'b1;
				pick = cand;
			end
		end
		issue = arb_ff == AR_IDLE && found;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			arb_ff <= AR_IDLE;
			owner_ff <= 2'h0;
			tokLeft_ff <= 6'h00;
			opValid_ff <= 1'b0;
			opFetch_ff <= 1'b0;
			opChan_ff <= 2'h0;
			opSrc_ff <= `DMC_CFG_RST;
			opDst_ff <= `DMC_CFG_RST;
			opBytes_ff <= 7'h00;
			opSrcStep_ff <= 1'b0;
			opDstStep_ff <= 1'b0;
			opPaired_ff <= 1'b0;
		end
		else
		begin
			case (arb_ff)
				AR_IDLE:
				begin
					if (issue)
					begin
						arb_ff <= AR_BUSY;
						owner_ff <= pick;
						if (pick == owner_ff && tokLeft_ff != 6'h00)
							tokLeft_ff <= tokLeft_ff - 6'h01; // RULE_03 RULE_04
						else
							tokLeft_ff <= tok[pick] - 6'h01;
						opValid_ff <= 1'b1;
						opChan_ff <= pick;
						opPaired_ff <= paired[pick];
						if (phase_ff[pick] == PH_FETCH)
						begin
							opFetch_ff <= 1'b1;
							opSrc_ff <= fetchBase_ff[pick]
								+ {28'h0000000, fetchIdx_ff[pick], 2'h0}; // RULE_24
							opDst_ff <= `DMC_CFG_RST;
							opBytes_ff <= 7'h04;
							opSrcStep_ff <= 1'b1;
							opDstStep_ff <= 1'b0;
						end
						else
						begin
							opFetch_ff <= 1'b0;
							opSrc_ff <= cmdSrc_ff[pick]; // RULE_13
							opDst_ff <= cmdDst_ff[pick];
							opBytes_ff <= moveBytes[pick];
							opSrcStep_ff <= rdCfg_ff[pick][`DMC_INC_BIT]; // RULE_01
							opDstStep_ff <= paired[pick]
								? rdCfg_ff[pick][`DMC_INC_BIT]
								: wrCfg_ff[pick][`DMC_INC_BIT]; // RULE_02
						end
					end
				end
				AR_BUSY:
				begin
					if (opDone)
					begin
						arb_ff <= AR_IDLE;
						opValid_ff <= 1'b0;
					end
				end
				default:
				begin
					arb_ff <= AR_IDLE;
					opValid_ff <= 1'b0;
				end
			endcase
		end
	end

	// Wait counter restarts whenever the request drops or an op of the channel goes out, fetch or move.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < NCH; i++)
				waitCnt_ff[i] <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (!reqHi[i] || (issue && pick == 2'(i)))
					waitCnt_ff[i] <= 3'h0; // RULE_07 RULE_09
				else if (waitCnt_ff[i] < waitNeed[i])
					waitCnt_ff[i] <= waitCnt_ff[i] + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			corePaired_ff <= 1'b0;
			irqEn_ff <= '0;
			run_ff <= '0;
			for (int i = 0; i < NCH; i++)
			begin
				rdCfg_ff[i] <= `DMC_CFG_RST;
				wrCfg_ff[i] <= `DMC_CFG_RST;
				modeCfg_ff[i] <= `DMC_CFG_RST;
				selCfg_ff[i] <= `DMC_CFG_RST;
			end
		end
		else
		begin
			if (regWrite && corePage && off == `DMC_OFF_CORE_PAIRED)
				corePaired_ff <= regWdata[0]; // RULE_05
			for (int i = 0; i < NCH; i++)
			begin
				if (chWr[i])
				begin
					case (off)
						`DMC_OFF_RD_STATIC: rdCfg_ff[i] <= regWdata; // RULE_10
						`DMC_OFF_WR_STATIC: wrCfg_ff[i] <= regWdata; // RULE_10
						`DMC_OFF_MODE_STATIC: modeCfg_ff[i] <= regWdata;
						`DMC_OFF_PERIPH_SEL: selCfg_ff[i] <= regWdata; // RULE_11
						`DMC_OFF_IRQ_EN: irqEn_ff[i] <= regWdata[0]; // RULE_15
						`DMC_OFF_RUN: run_ff[i] <= regWdata[0]; // RULE_19
						default:
						begin
						end
					endcase
				end
			end
		end
	end

	// Hardware updates of the command words win over a software write in
	// the same cycle, so an in-flight buffer never loses progress.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			kickPend_ff <= '0;
			doneFlag_ff <= '0;
			for (int i = 0; i < NCH; i++)
			begin
				phase_ff[i] <= PH_IDLE;
				cmdSrc_ff[i] <= `DMC_CFG_RST;
				cmdDst_ff[i] <= `DMC_CFG_RST;
				cmdLen_ff[i] <= `DMC_LEN_RST;
				cmdLink_ff[i] <= `DMC_CFG_RST;
				fetchBase_ff[i] <= `DMC_CFG_RST;
				fetchIdx_ff[i] <= 2'h0;
			end
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (chWr[i])
				begin
					case (off)
						`DMC_OFF_CMD_SRC: cmdSrc_ff[i] <= regWdata; // RULE_13
						`DMC_OFF_CMD_DST: cmdDst_ff[i] <= regWdata; // RULE_13
						`DMC_OFF_CMD_LEN:
							cmdLen_ff[i] <= regWdata[`DMC_LEN_W-1:0]; // RULE_14
						`DMC_OFF_CMD_LINK: cmdLink_ff[i] <= regWdata; // RULE_23
						`DMC_OFF_IRQ_FLAGS:
							if (regWdata[0])
								doneFlag_ff[i] <= 1'b0;
						default:
						begin
						end
					endcase
				end
				if (chWr[i] && off == `DMC_OFF_KICK && regWdata[0])
					kickPend_ff[i] <= 1'b1; // RULE_26
				if (kickPend_ff[i] && run_ff[i] && !(arb_ff == AR_BUSY
					&& owner_ff == 2'(i)))
				begin
					// A kick restarts from the command words as they stand.
					kickPend_ff[i] <= 1'b0; // RULE_17 RULE_21 RULE_26
					phase_ff[i] <= PH_MOVE;
				end
				else
				begin
					case (phase_ff[i])
						PH_MOVE:
						begin
							if (opBack[i])
							begin
								if (opSrcStep_ff)
									cmdSrc_ff[i] <= cmdSrc_ff[i] + {25'h0000000, opBytes_ff};
								if (opDstStep_ff)
									cmdDst_ff[i] <= cmdDst_ff[i] + {25'h0000000, opBytes_ff};
								cmdLen_ff[i] <= cmdLen_ff[i] - {6'h00, opBytes_ff};
							end
							else if (run_ff[i] && cmdLen_ff[i] == `DMC_LEN_RST)
								phase_ff[i] <= PH_END; // RULE_20
						end
						PH_END:
						begin
							if (cmdLink_ff[i][`DMC_CMD_INT_BIT]
								|| cmdLink_ff[i][`DMC_CMD_LAST_BIT])
								doneFlag_ff[i] <= 1'b1; // RULE_17 RULE_23
							if (cmdLink_ff[i][`DMC_CMD_LAST_BIT])
								phase_ff[i] <= PH_IDLE; // RULE_18 RULE_24
							else
							begin
								phase_ff[i] <= PH_FETCH; // RULE_24
								fetchBase_ff[i] <= {cmdLink_ff[i][31:2], 2'h0};
								fetchIdx_ff[i] <= 2'h0;
							end
						end
						PH_FETCH:
						begin
							if (opBack[i])
							begin
								case (fetchIdx_ff[i])
									2'h0: cmdSrc_ff[i] <= opRdata;
									2'h1: cmdDst_ff[i] <= opRdata;
									2'h2: cmdLen_ff[i] <= opRdata[`DMC_LEN_W-1:0];
									default: cmdLink_ff[i] <= opRdata;
								endcase
								fetchIdx_ff[i] <= fetchIdx_ff[i] + 2'h1;
								if (fetchIdx_ff[i] == 2'(`DMC_FETCH_WORDS - 1))
									phase_ff[i] <= PH_MOVE;
							end
						end
						PH_IDLE:
						begin
						end
						default: phase_ff[i] <= PH_IDLE;
					endcase
				end
			end
		end
	end

	always_comb
	begin
		allIdle = arb_ff == AR_IDLE;
		for (int i = 0; i < NCH; i++)
			if (phase_ff[i] != PH_IDLE)
				allIdle = 1'b0;
		nxt_rdata = 32'h00000000;
		if (corePage)
		begin
			if (off == `DMC_OFF_CORE_PAIRED)
				nxt_rdata = {31'h00000000, corePaired_ff};
			else if (off == `DMC_OFF_CORE_IDLE)
				nxt_rdata = {31'h00000000, coreIdle_ff};
		end
		else
		begin
			case (off)
				`DMC_OFF_RD_STATIC: nxt_rdata = rdCfg_ff[regCh];
				`DMC_OFF_WR_STATIC: nxt_rdata = wrCfg_ff[regCh];
				`DMC_OFF_MODE_STATIC: nxt_rdata = modeCfg_ff[regCh];
				`DMC_OFF_PERIPH_SEL: nxt_rdata = selCfg_ff[regCh];
				`DMC_OFF_CMD_SRC: nxt_rdata = cmdSrc_ff[regCh];
				`DMC_OFF_CMD_DST: nxt_rdata = cmdDst_ff[regCh];
				`DMC_OFF_CMD_LEN: nxt_rdata = {19'h00000, cmdLen_ff[regCh]};
				`DMC_OFF_CMD_LINK: nxt_rdata = cmdLink_ff[regCh];
				`DMC_OFF_IRQ_EN: nxt_rdata = {31'h00000000, irqEn_ff[regCh]};
				`DMC_OFF_RUN: nxt_rdata = {31'h00000000, run_ff[regCh]};
				`DMC_OFF_IRQ_FLAGS: nxt_rdata = {31'h00000000, doneFlag_ff[regCh]};
				`DMC_OFF_ACTIVITY:
					nxt_rdata = {30'h00000000, {2{phase_ff[regCh] != PH_IDLE}}}; // RULE_18
				default: nxt_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			regRdata_ff <= 32'h00000000;
			irqOut_ff <= 1'b0;
			coreIdle_ff <= 1'b0;
		end
		else
		begin
			regRdata_ff <= regRead ? nxt_rdata : 32'h00000000;
			irqOut_ff <= |(doneFlag_ff & irqEn_ff); // RULE_15 RULE_16 RULE_25
			coreIdle_ff <= allIdle; // RULE_22
		end
	end

endmodule : dmc_channel_control
`default_nettype wire

// >>> dv/dmc_mover_model.sv
// Behavioural data mover on the far side of the op port.
// Assumes one op at a time on core_clk; a fetch reads DESC words.
`timescale 1ns/1ps
`default_nettype none
module dmc_mover_model
#(
	parameter logic [127:0] DESC = 128'h0
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic opValid_ff,
	input wire logic [31:0] opSrc_ff,
	input wire logic [3:0] lat,
	output logic opDone,
	output logic [31:0] opRdata
);
	logic done_ff;
	logic [3:0] waitCnt_ff;
	logic [31:0] data_ff;
	assign opDone = done_ff;
	assign opRdata = data_ff;
	// Off the done cycle the word toggles, so a late sample is caught.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			done_ff <= 1'b0;
			waitCnt_ff <= 4'h0;
			data_ff <= 32'h0;
		end
		else if (opValid_ff && !done_ff && waitCnt_ff == lat)
		begin
			done_ff <= 1'b1;
			waitCnt_ff <= 4'h0;
			data_ff <= DESC[32 * opSrc_ff[3:2] +: 32];
		end
		else
		begin
			done_ff <= 1'b0;
			waitCnt_ff <= (opValid_ff && !done_ff) ? waitCnt_ff + 4'h1 : 4'h0;
			data_ff <= ~data_ff;
		end
	end
endmodule : dmc_mover_model
`default_nettype wire

// >>> dv/dmc_channel_control_asserts.sv
// Port checks of the DMA channel control block.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_cfg.svh"
module dmc_channel_control_asserts
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [`DMC_ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdata_ff,
	input wire logic opValid_ff,
	input wire logic opFetch_ff,
	input wire logic [31:0] opSrc_ff,
	input wire logic [31:0] opDst_ff,
	input wire logic [6:0] opBytes_ff,
	input wire logic opDone,
	input wire logic irqOut_ff,
	input wire logic coreIdle_ff
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);
	AST_RDATA_QUIET: assert property (!$past(regRead) |-> !regRdata_ff)
		else $error("read data not zero outside a read answer");
	AST_UNMAPPED: assert property (regRead && regAddr == 9'h00C |=>
		regRdata_ff == 32'h0) else $error("unmapped offset read not zero");
	AST_OP_STABLE: assert property (opValid_ff && $past(opValid_ff) |->
		$stable(opSrc_ff) && $stable(opDst_ff) && $stable(opBytes_ff))
		else $error("op fields moved while outstanding");
	AST_OP_HOLD: assert property (opValid_ff && !opDone |=> opValid_ff)
		else $error("op dropped before done");
	AST_OP_END: assert property (opValid_ff && opDone |=> !opValid_ff)
		else $error("op kept after done");
	AST_FETCH_FORM: assert property (opValid_ff && opFetch_ff |->
		opBytes_ff == 7'h04 && opDst_ff == 32'h0)
		else $error("fetch op not one word");
	AST_IDLE_NO_OP: assert property (opValid_ff |-> !coreIdle_ff)
		else $error("core idle with op outstanding");
	AST_IDLE_RISE: assert property ($rose(coreIdle_ff) |->
		!$past(opValid_ff)) else $error("idle rose right after an op");
	AST_IRQ_FALL: assert property ($fell(irqOut_ff) |-> $past(regWrite) ||
		$past(regWrite, 2) || $past(regWrite, 3))
		else $error("interrupt fell without a register write");
endmodule : dmc_channel_control_asserts
bind dmc_channel_control dmc_channel_control_asserts CHECKER (.core_clk,
	.reset, .regAddr, .regWrite, .regRead, .regRdata_ff, .opValid_ff,
	.opFetch_ff, .opSrc_ff, .opDst_ff, .opBytes_ff, .opDone, .irqOut_ff,
	.coreIdle_ff);
`default_nettype wire

// >>> dv/test_dmc_channel_control.sv
// Self-checking bench for the DMA channel control block.
// Assumes the mover model answers every op on the op port.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_cfg.svh"
`define CHK(n, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("unexpected %s: expected %h seen %h", n, e, g); \
		end \
	end
module test_dmc_channel_control;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [`DMC_ADDR_W-1:0] regAddr = 9'h000;
	logic [31:0] regWdata = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] periphReq = 32'h0;
	logic [3:0] lat = 4'h0;
	logic [31:0] regRdata_ff, opSrc_ff, opDst_ff, opRdata;
	logic opValid_ff, opFetch_ff, opSrcStep_ff, opDstStep_ff, opPaired_ff;
	logic opDone, irqOut_ff, coreIdle_ff;
	logic [1:0] opChan_ff;
	logic [6:0] opBytes_ff;
	int err_count = 0;
	int n_checks = 0;
	int cycleCnt = 0;
	logic [1:0] curCh = 2'h0;
	localparam logic [5:0] OFF[10] = '{`DMC_OFF_RD_STATIC,
		`DMC_OFF_WR_STATIC, `DMC_OFF_MODE_STATIC, `DMC_OFF_PERIPH_SEL,
		`DMC_OFF_CMD_SRC, `DMC_OFF_CMD_DST, `DMC_OFF_CMD_LEN,
		`DMC_OFF_CMD_LINK, `DMC_OFF_IRQ_EN, `DMC_OFF_ACTIVITY};
	// Static and select words keep every written bit, so all read back.
	localparam logic [31:0] MSK[10] = '{32'hFFFFFFFF, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
		32'h00001FFF, 32'hFFFFFFFF, 32'h00000001, 32'h00000000};

	dmc_channel_control DUT (.core_clk, .reset, .regAddr, .regWdata,
		.regWrite, .regRead, .regRdata_ff, .periphReq, .opValid_ff,
		.opFetch_ff, .opChan_ff, .opSrc_ff, .opDst_ff, .opBytes_ff,
		.opSrcStep_ff, .opDstStep_ff, .opPaired_ff, .opDone, .opRdata,
		.irqOut_ff, .coreIdle_ff);
	dmc_mover_model #(.DESC(128'h00000003_00000004_00006000_00005000))
		MOVER (.core_clk, .reset, .opValid_ff, .opSrc_ff, .lat, .opDone,
		.opRdata);

	always #25 core_clk = ~core_clk;

	function automatic logic [8:0] ca(input logic [1:0] c, input logic [5:0] o);
		return {1'b0, c, o};
	endfunction : ca

	task automatic wrap_up;
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		`CHK($sformatf("register %h", a), e, regRdata_ff)
	endtask : rd

	task automatic till(input logic v);
		for (int n = 0; n < 300 && opValid_ff !== v; n++)
		begin
			@(posedge core_clk);
			#1;
		end
	endtask : till

	task automatic quiet(input int c);
		logic seen;
		seen = 1'b0;
		repeat (c)
		begin
			@(posedge core_clk);
			#1;
			seen = seen | opValid_ff;
		end
		`CHK("no op", 1'b0, seen)
	endtask : quiet

	task automatic wait_op(input logic [31:0] s, input logic [6:0] b,
		input logic f, input logic [2:0] m);
		till(1'b0);
		till(1'b1);
		`CHK("op source", s, opSrc_ff)
		`CHK("op bytes", b, opBytes_ff)
		`CHK("op fetch", f, opFetch_ff)
		`CHK("op channel", curCh, opChan_ff)
		if (!f)
			`CHK("op modes", m, {opSrcStep_ff, opDstStep_ff, opPaired_ff})
	endtask : wait_op

	task automatic setup(input logic [1:0] c,
		input logic [31:0] r, w, p, s, d, l, k);
		curCh = c;
		wr(ca(c, `DMC_OFF_RD_STATIC), r);
		wr(ca(c, `DMC_OFF_WR_STATIC), w);
		wr(ca(c, `DMC_OFF_PERIPH_SEL), p);
		wr(ca(c, `DMC_OFF_CMD_SRC), s);
		wr(ca(c, `DMC_OFF_CMD_DST), d);
		wr(ca(c, `DMC_OFF_CMD_LEN), l);
		wr(ca(c, `DMC_OFF_CMD_LINK), k);
	endtask : setup

	task automatic done_chk(input logic [1:0] c, input logic e);
		till(1'b0);
		repeat (6) @(posedge core_clk);
		#1;
		`CHK("irq", e, irqOut_ff)
		`CHK("idle", 1'b1, coreIdle_ff)
		rd(ca(c, `DMC_OFF_IRQ_FLAGS), 32'h1);
		rd(ca(c, `DMC_OFF_ACTIVITY), 32'h0);
		wr(ca(c, `DMC_OFF_IRQ_EN), 32'h1);
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("irq enabled", 1'b1, irqOut_ff)
		wr(ca(c, `DMC_OFF_IRQ_FLAGS), 32'h1);
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("irq cleared", 1'b0, irqOut_ff)
		rd(ca(c, `DMC_OFF_IRQ_FLAGS), 32'h0);
	endtask : done_chk

	// A hung handshake ends the run here as a counted mismatch.
	always @(posedge core_clk)
	begin
		cycleCnt++;
		if (cycleCnt == 20000)
		begin
			err_count++;
			wrap_up;
		end
	end

	initial
	begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("idle after reset", 1'b1, coreIdle_ff)
		rd(9'h104, 32'h1);
		rd(9'h00C, 32'h0);
		foreach (OFF[i])
		begin
			wr(ca(2'h0, OFF[i]), 32'hFFFFFFFF);
			rd(ca(2'h0, OFF[i]), MSK[i]);
		end
		rd(ca(2'h0, `DMC_OFF_KICK), 32'h0);
		setup(2'h0, 32'h80010004, 32'h80010004, 32'h0, 32'h1000, 32'h2000,
			32'h8, 32'h3);
		wr(9'h100, 32'h1);
		rd(9'h100, 32'h1);
		wr(ca(2'h0, `DMC_OFF_RUN), 32'h1);
		wr(ca(2'h0, `DMC_OFF_KICK), 32'h1);
		wait_op(32'h1000, 7'h04, 1'b0, 3'b111);
		wait_op(32'h1004, 7'h04, 1'b0, 3'b111);
		done_chk(2'h0, 1'b1);
		wr(9'h100, 32'h0);
		lat <= 4'h8;
		setup(2'h1, 32'h80010008, 32'h00010004, 32'h0, 32'h3000, 32'h4000,
			32'h8, 32'h3);
		wr(ca(2'h1, `DMC_OFF_IRQ_EN), 32'h0);
		wr(ca(2'h1, `DMC_OFF_RUN), 32'h0);
		wr(ca(2'h1, `DMC_OFF_KICK), 32'h1);
		quiet(20);
		wr(ca(2'h1, `DMC_OFF_RUN), 32'h1);
		wait_op(32'h3000, 7'h04, 1'b0, 3'b100);
		wr(ca(2'h1, `DMC_OFF_RUN), 32'h0);
		till(1'b0);
		quiet(20);
		rd(ca(2'h1, `DMC_OFF_ACTIVITY), 32'h3);
		`CHK("busy core", 1'b0, coreIdle_ff)
		wr(ca(2'h1, `DMC_OFF_RUN), 32'h1);
		wait_op(32'h3004, 7'h04, 1'b0, 3'b100);
		done_chk(2'h1, 1'b0);
		lat <= 4'h1;
		setup(2'h2, 32'h80010004, 32'h80010004, 32'h0, 32'h0, 32'h0, 32'h0,
			32'h20);
		wr(ca(2'h2, `DMC_OFF_IRQ_EN), 32'h0);
		wr(ca(2'h2, `DMC_OFF_RUN), 32'h1);
		wr(ca(2'h2, `DMC_OFF_KICK), 32'h1);
		for (int i = 0; i < 4; i++)
			wait_op(32'h20 + 4 * i, 7'h04, 1'b1, 3'b000);
		wait_op(32'h5000, 7'h04, 1'b0, 3'b110);
		done_chk(2'h2, 1'b0);
		setup(2'h3, 32'h80010004, 32'h00010004, 32'h01020000, 32'h7000,
			32'h8000, 32'h4, 32'h3);
		wr(ca(2'h3, `DMC_OFF_IRQ_EN), 32'h0);
		wr(ca(2'h3, `DMC_OFF_RUN), 32'h1);
		wr(ca(2'h3, `DMC_OFF_KICK), 32'h1);
		quiet(20);
		periphReq <= 32'h4;
		wait_op(32'h7000, 7'h04, 1'b0, 3'b100);
		periphReq <= 32'h0;
		done_chk(2'h3, 1'b0);
		wrap_up;
	end
endmodule : test_dmc_channel_control
`default_nettype wire
